/* pkg/eeq_pkg.sv */
// Operation
// (R1) The queue holds at most ten pending entries.
// (R2) Reads return the oldest pending entry first.
// (R3) A returned entry is removed so the next read gets the next one.
// (R4) The error indicator is high while any recorded error is pending.
// (R5) The indicator drops once the last entry is read out.
// (R6) Each new recorded error gives exactly one beep pulse.
// (R7) An error arriving on a full queue overwrites the newest entry with overflow.
// (R8) After overflow, arriving errors are dropped until a read removes one.
// (R9) A read on an empty queue returns no-error and changes nothing.
// (R10) Clear-status or power cycle empties the queue and drops the indicator.
// (R11) Instrument reset and preset leave queue and indicator untouched.
// (R12) An entry is a signed code plus a message of up to eighty characters.
// (R13) Leaving the local error view flushes every pending entry at once.
// (R14) A failed complete self-test records an error and raises the indicator.
// (R15) The indicator stays live while the display is disabled.
// (R16) Overflow and empty responses use fixed codes no recordable error uses.
`default_nettype none
package eeq_pkg;
    // -----------------------------------------------------------------
    // Queue shape
    // -----------------------------------------------------------------
    localparam int          DEPTH      = 10;
    localparam int          CODE_W     = 16;
    localparam int          MSG_CHARS  = 80;
    localparam int          MSG_W      = MSG_CHARS * 8;
    // -----------------------------------------------------------------
    // Reserved codes
    // -----------------------------------------------------------------
    localparam logic [15:0] CODE_NONE  = 16'h0000;
    localparam logic [15:0] CODE_OVFL  = 16'hfebe;
    localparam logic [15:0] CODE_SELFT = 16'hfe0c;
    localparam logic [7:0]  LEN_ZERO   = 8'h00;
endpackage
`default_nettype wire

/* verilog/eeq_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module eeq_queue #(
    parameter int DEPTH     = eeq_pkg::DEPTH,
    parameter int CODE_W    = eeq_pkg::CODE_W,
    parameter int MSG_CHARS = eeq_pkg::MSG_CHARS
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   err_valid,
    input  wire logic [CODE_W-1:0]      err_code,
    input  wire logic [MSG_CHARS*8-1:0] err_msg,
    input  wire logic [7:0]             err_len,
    input  wire logic                   selftest_fail,
    input  wire logic                   read_req,
    input  wire logic                   clear_status,
    input  wire logic                   view_exit,
    input  wire logic                   instr_reset,
    input  wire logic                   instr_preset,
    input  wire logic                   display_off,
    output logic                        resp_valid,
    output logic [CODE_W-1:0]           resp_code,
    output logic [MSG_CHARS*8-1:0]      resp_msg,
    output logic [7:0]                  resp_len,
    output logic                        error_ind,
    output logic                        beep,
    output logic [3:0]                  count
);
    localparam int MW = MSG_CHARS * 8;
    localparam int PW = $clog2(DEPTH);

    // -----------------------------------------------------------------
    // Parameter check
    // -----------------------------------------------------------------
    // Occupancy is a four-bit port, so deeper queues would need a wider count.
    if (DEPTH < 2 || DEPTH > 15) begin : g_bad_depth
        $error("eeq_queue: unsupported queue depth.");
    end
    // Lengths travel in eight bits and reserved codes are sixteen bits wide.
    if (MSG_CHARS < 1 || MSG_CHARS > 255 || CODE_W != 16) begin : g_bad_entry
        $error("eeq_queue: unsupported entry shape.");
    end

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    logic [CODE_W-1:0] mem_code [DEPTH];
    logic [MW-1:0]     mem_msg  [DEPTH];
    logic [7:0]        mem_len  [DEPTH];

    // -----------------------------------------------------------------
    // Queue state and next values
    // -----------------------------------------------------------------
    logic [PW-1:0]     rd_ptr;
    logic [PW-1:0]     next_rd_ptr;
    logic [3:0]        next_count;
    logic              ovfl_lock;
    logic              next_ovfl_lock;
    logic              next_resp_valid;
    logic [CODE_W-1:0] next_resp_code;
    logic [MW-1:0]     next_resp_msg;
    logic [7:0]        next_resp_len;
    logic              next_error_ind;
    logic              next_beep;
    logic              wr_en;
    logic [PW-1:0]     wr_idx;
    logic [CODE_W-1:0] wr_code;
    logic [MW-1:0]     wr_msg;
    logic [7:0]        wr_len;
    logic              arrive;
    logic [CODE_W-1:0] in_code;
    logic              do_read;
    logic [3:0]        cnt_after_rd;
    logic [PW-1:0]     tail;

    // -----------------------------------------------------------------
    // Pins with no effect
    // -----------------------------------------------------------------
    // Instrument reset and preset are deliberately not consumed here.
    // Display blanking must never reach the indicator path.
    logic unused_ok;
    assign unused_ok = instr_reset ^ instr_preset ^ display_off; // [R11] [R15]

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // Pointers wrap at DEPTH, which need not be a power of two.
    function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] p, input logic [3:0] n);
        logic [4:0] s;
        s = 5'(p) + 5'(n);
        if (s >= 5'(DEPTH)) begin
            s = s - 5'(DEPTH);
        end
        return s[PW-1:0];
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        arrive         = err_valid | selftest_fail; // [R14]
        in_code        = selftest_fail ? eeq_pkg::CODE_SELFT : err_code;
        do_read        = read_req && count != 4'h0;
        cnt_after_rd   = do_read ? count - 4'h1 : count;
        next_rd_ptr    = do_read ? wrap_add(rd_ptr, 4'h1) : rd_ptr; // [R2] [R3]
        next_count     = cnt_after_rd;
        next_ovfl_lock = do_read ? 1'b0 : ovfl_lock; // [R8]
        next_beep      = 1'b0;
        wr_en          = 1'b0;
        wr_code        = in_code;
        wr_msg         = selftest_fail ? {MW{1'b0}} : err_msg;
        wr_len         = selftest_fail ? eeq_pkg::LEN_ZERO : err_len; // [R12]
        tail           = wrap_add(next_rd_ptr, cnt_after_rd);
        wr_idx         = tail;
        // Arrival is judged after this cycle's read, so a read and a write together never overflow.
        if (arrive && !next_ovfl_lock) begin
            next_beep = 1'b1; // [R6]
            wr_en     = 1'b1;
            // The overflow entry takes the newest slot, so older errors keep their order.
            if (cnt_after_rd == 4'(DEPTH)) begin // [R1]
                wr_idx         = wrap_add(next_rd_ptr, 4'(DEPTH - 1)); // [R7]
                wr_code        = eeq_pkg::CODE_OVFL; // [R16]
                wr_msg         = {MW{1'b0}};
                wr_len         = eeq_pkg::LEN_ZERO;
                next_ovfl_lock = 1'b1; // [R8]
            end else begin
                next_count = cnt_after_rd + 4'h1;
            end
        end
        // Clear and view exit win over a same-cycle arrival, which is not stored though it still gives a beep pulse.
        if (clear_status || view_exit) begin // [R10] [R13]
            next_count     = 4'h0;
            next_rd_ptr    = '0;
            next_ovfl_lock = 1'b0;
            wr_en          = 1'b0;
        end
        next_error_ind = next_count != 4'h0; // [R4] [R5] [R15]
    end

    // -----------------------------------------------------------------
    // Queue state registers
    // -----------------------------------------------------------------
    // Pointer, occupancy and lock move together; a power-cycle reset clears them all.
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr    <= '0;
            count     <= 4'h0;
            ovfl_lock <= 1'b0;
            error_ind <= 1'b0;
            beep      <= 1'b0;
        end else begin
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            ovfl_lock <= next_ovfl_lock;
            error_ind <= next_error_ind;
            beep      <= next_beep;
        end
    end

    // -----------------------------------------------------------------
    // Response
    // -----------------------------------------------------------------
    // The answer words hold until the next read, so a slow host may pick them up late.
    always_comb begin
        next_resp_valid = read_req;
        next_resp_code  = resp_code;
        next_resp_msg   = resp_msg;
        next_resp_len   = resp_len;
        if (read_req) begin
            if (do_read) begin
                next_resp_code = mem_code[rd_ptr]; // [R2]
                next_resp_msg  = mem_msg[rd_ptr];
                next_resp_len  = mem_len[rd_ptr];
            end else begin
                next_resp_code = eeq_pkg::CODE_NONE; // [R9] [R16]
                next_resp_msg  = {MW{1'b0}};
                next_resp_len  = eeq_pkg::LEN_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_code  <= eeq_pkg::CODE_NONE;
            resp_msg   <= '0;
            resp_len   <= eeq_pkg::LEN_ZERO;
        end else begin
            resp_valid <= next_resp_valid;
            resp_code  <= next_resp_code;
            resp_msg   <= next_resp_msg;
            resp_len   <= next_resp_len;
        end
    end

    // -----------------------------------------------------------------
    // Entry storage
    // -----------------------------------------------------------------
    // Entries need no reset; count decides which are live.
    // Each slot compares the write index with its own number.
    for (genvar e = 0; e < DEPTH; e++) begin : g_entry
        logic [CODE_W-1:0] next_code;
        logic [MW-1:0]     next_msg;
        logic [7:0]        next_len;

        always_comb begin
            next_code = mem_code[e];
            next_msg  = mem_msg[e];
            next_len  = mem_len[e];
            if (wr_en && wr_idx == PW'(e)) begin // [R1] [R7]
                next_code = wr_code;
                next_msg  = wr_msg;
                next_len  = wr_len;
            end
        end

        always_ff @(posedge clk) begin
            mem_code[e] <= next_code;
            mem_msg[e]  <= next_msg;
            mem_len[e]  <= next_len;
        end
    end
endmodule
`default_nettype wire

/* verif/eeq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module eeq_checker #(parameter int DEPTH = 10) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        err_valid,
    input wire logic        selftest_fail,
    input wire logic        read_req,
    input wire logic        clear_status,
    input wire logic        view_exit,
    input wire logic        instr_reset,
    input wire logic        instr_preset,
    input wire logic        resp_valid,
    input wire logic [15:0] resp_code,
    input wire logic        error_ind,
    input wire logic        beep,
    input wire logic [3:0]  count
);
    logic arr;
    logic clr;
    assign arr = err_valid | selftest_fail;
    assign clr = clear_status | view_exit;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_depth; count <= DEPTH; endproperty
    a_depth: assert property (p_depth) else $error("occupancy above depth");
    property p_ind; error_ind == (count != 4'h0); endproperty
    a_ind: assert property (p_ind) else $error("indicator disagrees with occupancy");
    property p_beep; arr && !clr && count < DEPTH |=> beep; endproperty
    a_beep: assert property (p_beep) else $error("no beep for new error");
    property p_cause; beep |-> $past(arr); endproperty
    a_cause: assert property (p_cause) else $error("beep without error");
    property p_empty; read_req && count == 4'h0 && !arr |=> resp_valid
        && resp_code == eeq_pkg::CODE_NONE && count == 4'h0; endproperty
    a_empty: assert property (p_empty) else $error("bad empty read");
    property p_pop; read_req && count != 4'h0 && !arr && !clr |=> count == $past(count) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not remove entry");
    property p_clear; clr |=> count == 4'h0 && !error_ind; endproperty
    a_clear: assert property (p_clear) else $error("clear left entries");
    property p_resp; resp_valid |-> $past(read_req); endproperty
    a_resp: assert property (p_resp) else $error("answer without read");
    property p_full; count == DEPTH && arr && !read_req && !clr |=> count == DEPTH; endproperty
    a_full: assert property (p_full) else $error("full queue grew or shrank");
    property p_keep; (instr_reset || instr_preset) && !arr && !read_req && !clr
        |=> count == $past(count) && error_ind == $past(error_ind); endproperty
    a_keep: assert property (p_keep) else $error("reset or preset touched the queue");
    cover property (count == DEPTH && err_valid);
    cover property (read_req && count == 4'h0);
    cover property (clear_status && count != 4'h0);
endmodule
bind eeq_queue eeq_checker #(.DEPTH(DEPTH)) i_eeq_checker (
    .clk           (clk),
    .rst           (rst),
    .err_valid     (err_valid),
    .selftest_fail (selftest_fail),
    .read_req      (read_req),
    .clear_status  (clear_status),
    .view_exit     (view_exit),
    .instr_reset   (instr_reset),
    .instr_preset  (instr_preset),
    .resp_valid    (resp_valid),
    .resp_code     (resp_code),
    .error_ind     (error_ind),
    .beep          (beep),
    .count         (count)
);
`default_nettype wire

/* verif/eeq_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Queries launch on the falling edge so the queue samples a settled request.
module eeq_host (
    input  wire logic clk,
    input  wire logic go,
    output var  logic read_req
);
    initial read_req = 1'b0;
    always @(negedge clk) read_req <= go;
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         err_valid = 1'b0;
    logic [15:0]  err_code = 16'h0000;
    logic [639:0] err_msg = '0;
    logic [7:0]   err_len = 8'h00;
    logic [4:0]   ctl = 5'h00;
    logic         go = 1'b0;
    logic         display_off = 1'b0;
    wire logic    selftest_fail, clear_status, view_exit, instr_reset, instr_preset;
    logic         read_req, resp_valid, error_ind, beep;
    logic [15:0]  resp_code;
    logic [639:0] resp_msg;
    logic [7:0]   resp_len;
    logic [3:0]   count;
    int           n_errors = 0;
    int           n_checks = 0;
    int           i, k;
    // Top bit set means a read expecting the code, clear means an arriving error.
    logic [16:0]  rows [7] = '{17'h00071, 17'h00f2c, 17'h0ff9b, 17'h10071, 17'h10f2c,
                               17'h1ff9b, 17'h10000};
    assign {view_exit, clear_status, selftest_fail, instr_preset, instr_reset} = ctl;
    eeq_queue i_eeq_queue (
        .clk           (clk),
        .rst           (rst),
        .err_valid     (err_valid),
        .err_code      (err_code),
        .err_msg       (err_msg),
        .err_len       (err_len),
        .selftest_fail (selftest_fail),
        .read_req      (read_req),
        .clear_status  (clear_status),
        .view_exit     (view_exit),
        .instr_reset   (instr_reset),
        .instr_preset  (instr_preset),
        .display_off   (display_off),
        .resp_valid    (resp_valid),
        .resp_code     (resp_code),
        .resp_msg      (resp_msg),
        .resp_len      (resp_len),
        .error_ind     (error_ind),
        .beep          (beep),
        .count         (count)
    );
    eeq_host i_eeq_host (
        .clk      (clk),
        .go       (go),
        .read_req (read_req)
    );
    initial forever #50 clk = ~clk;
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task put(input logic [15:0] c, input logic b);
        @(negedge clk);
        err_valid = 1'b1;
        err_code = c;
        err_msg = {40{c}};
        err_len = 8'(c[5:0]);
        @(negedge clk);
        err_valid = 1'b0;
        chk(16'(beep), 16'(b));
    endtask
    task pulse(input logic [4:0] v);
        @(negedge clk);
        ctl = v;
        @(negedge clk);
        ctl = 5'h00;
    endtask
    task get(input logic [15:0] e);
        logic rsv;
        rsv = e == eeq_pkg::CODE_NONE || e == eeq_pkg::CODE_OVFL || e == eeq_pkg::CODE_SELFT;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 6; i++) begin
            @(negedge clk);
            if (resp_valid === 1'b1) break;
        end
        if (i == 6) begin
            n_errors++;
            end_sim();
        end else begin
            chk(resp_code, e);
            chk(16'(resp_len), rsv ? 16'h0000 : 16'(e[5:0]));
            chk(16'(resp_msg === (rsv ? 640'h0 : {40{e}})), 16'h0001);
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (k = 0; k < 7; k++) begin
            if (rows[k][16]) get(rows[k][15:0]);
            else put(rows[k][15:0], 1'b1);
        end
        chk(16'(error_ind), 16'h0000);
        for (k = 1; k <= 11; k++) put(16'(k), 1'b1);
        put(16'h0123, 1'b0);
        chk(16'(count), 16'h000a);
        get(16'h0001);
        put(16'h0124, 1'b1);
        for (k = 2; k <= 9; k++) get(16'(k));
        get(eeq_pkg::CODE_OVFL);
        get(16'h0124);
        get(eeq_pkg::CODE_NONE);
        display_off = 1'b1;
        put(16'h0055, 1'b1);
        pulse(5'h01);
        pulse(5'h02);
        chk(16'(error_ind), 16'h0001);
        pulse(5'h08);
        chk(16'(count), 16'h0000);
        pulse(5'h04);
        chk(16'(error_ind), 16'h0001);
        get(eeq_pkg::CODE_SELFT);
        put(16'h0066, 1'b1);
        put(16'h0077, 1'b1);
        pulse(5'h10);
        chk(16'(count), 16'h0000);
        put(16'h0088, 1'b1);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk(16'(count), 16'h0000);
        chk(16'(error_ind), 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
